// file: rtl/tlpic_defs.svh
/*
 * constants for the two-level priority interrupt controller: vectors,
 * control bit positions, reset values and latency counts.
 * assumes inclusion by bare name from the design and the testbench.
 */
`ifndef TLPIC_DEFS_SVH
`define TLPIC_DEFS_SVH

`define TLPIC_VEC_HIGH        21'h000008
`define TLPIC_VEC_LOW         21'h000018
`define TLPIC_BIT_GIE_HIGH    7
`define TLPIC_BIT_GIE_LOW     6
`define TLPIC_BIT_PRIO_EN     7
`define TLPIC_RST_CTRL        8'h00
`define TLPIC_CYCLE_NS        100
`define TLPIC_INSTR_NS        400
`define TLPIC_CLK_PER_INSTR   (`TLPIC_INSTR_NS / `TLPIC_CYCLE_NS)
`define TLPIC_EXT_DELAY       3
// clocks a synchronised pin edge waits before its flag; synchroniser and
// flag stage take the other four clocks of the event-to-vector path
`define TLPIC_PIN_WAIT        (`TLPIC_EXT_DELAY * `TLPIC_CLK_PER_INSTR - 4)

`endif

// file: rtl/tlpic_pkg.sv
/*
 * types for the two-level priority interrupt controller.
 * assumes tlpic_defs.svh is on the include path.
 */
package tlpic_pkg;
	typedef enum logic [1:0]
	{
		TLPIC_IDLE = 2'b00,
		TLPIC_LOW  = 2'b01,
		TLPIC_HIGH = 2'b10,
		TLPIC_NEST = 2'b11
	} tlpic_level_type;
endpackage

// file: rtl/tlpic_ctrl.sv
/*
 * two-level priority interrupt controller: flags, enables, priority,
 * global enables, vector select, entry and return handling.
 * assumes the core pulses handler_return on the return instruction and
 * pulses take-over of the vector on vector_request; control bits arrive
 * as plain ports, strobed only for priority_scheme_enable and the global enables; pins are asynchronous.
 */
// Operation
// - with priority on, high requests go to 000008h, low to 000018h
// - a high request may preempt a running low handler, one nest level
// - every source has a flag, an enable and a priority select
// - two-level scheme active only while priority_scheme_enable is set
// - priority on: bit7 enables high sources, bit6 enables low sources
// - flag, enable and applicable global enable set: vector at once unless a handler at that level or above runs
// - priority_scheme_enable resets cleared; priority bits then ignored
// - compatibility: bit6 gates peripheral sources, bit7 gates all
// - compatibility: every accepted request vectors to 000008h
// - accepting clears the governing global enable
// - low requests held off while a high handler runs
// - core pushes return address and loads vector into program_counter
// - return instruction sets the global enable cleared on entry; the low one is set only while priority_scheme_enable is set
// - external pin and port change events vector in three to four cycles
// - external latency independent of one or two cycle instructions
// - flags set on events regardless of any enable
// - per pin edge select, 1 rising, 0 falling
// - port change flag set on any change of upper port B bits, sticky
`timescale 1ns/1ps
`include "tlpic_defs.svh"

module tlpic_ctrl
#(
	parameter int NUM_PERIPH = 8,
	parameter int NUM_EXT    = 3
)
(
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	// control bits
	input  wire logic                  priority_scheme_enable_wr,
	input  wire logic                  priority_scheme_enable_in,
	input  wire logic                  global_high_wr,
	input  wire logic                  global_high_in,
	input  wire logic                  global_low_wr,
	input  wire logic                  global_low_in,
	input  wire logic [NUM_PERIPH-1:0] periph_enable,
	input  wire logic [NUM_PERIPH-1:0] periph_priority,
	input  wire logic [NUM_EXT-1:0]    ext_enable,
	input  wire logic [NUM_EXT-1:0]    ext_priority,
	input  wire logic [NUM_EXT-1:0]    external_edge_select,
	input  wire logic                  port_change_enable,
	input  wire logic                  port_change_priority,
	// flag clears from software
	input  wire logic [NUM_PERIPH-1:0] periph_flag_clear,
	input  wire logic [NUM_EXT-1:0]    ext_flag_clear,
	input  wire logic                  port_change_flag_clear,
	// event sources
	input  wire logic [NUM_PERIPH-1:0] periph_event,
	input  wire logic [NUM_EXT-1:0]    external_interrupt_pins,
	input  wire logic [3:0]            port_b_upper,
	// core side
	input  wire logic                  handler_return,
	output logic                       vector_request,
	output logic [20:0]                vector_address,
	output logic                       vector_is_high,
	// status
	output logic                       priority_scheme_enable,
	output logic                       high_priority_global_enable,
	output logic                       low_priority_global_enable,
	output logic [NUM_PERIPH-1:0]      periph_flag,
	output logic [NUM_EXT-1:0]         ext_flag,
	output logic                       port_change_flag,
	output tlpic_pkg::tlpic_level_type handler_level
);

	if (NUM_PERIPH < 1 || NUM_EXT < 1 || NUM_EXT > 8)
	begin : g_bad_counts
		$error("tlpic_ctrl: source counts out of range");
	end

	localparam int NPIN = NUM_EXT + 4;

	// three-stage synchronisers on all pins
	logic [NPIN-1:0] sync1;
	logic [NPIN-1:0] sync2;
	logic [NPIN-1:0] sync3;
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end
		else
		begin
			sync1 <= {port_b_upper, external_interrupt_pins};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// stable level: moves once stages 2 and 3 agree
	logic [NPIN-1:0] pin_level;
	logic [NPIN-1:0] next_level;
	// edges masked until pin_level holds a real sample, one clock after stage 3: no false edge after reset
	logic [3:0]      pin_primed;
	always_comb
	begin
		next_level = pin_level;
		for (int i = 0; i < NPIN; i++)
			if (sync2[i] == sync3[i])
				next_level[i] = sync2[i];
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			pin_level  <= '0;
			pin_primed <= '0;
		end
		else
		begin
			pin_level  <= next_level;
			pin_primed <= {pin_primed[2:0], 1'b1};
		end
	end

	logic [NUM_EXT-1:0] ext_edge;
	logic               port_change;
	genvar g;
	generate
		for (g = 0; g < NUM_EXT; g++)
		begin : g_ext
			// edge polarity per pin
			assign ext_edge[g] = pin_primed[3] && (next_level[g] != pin_level[g]) &&
				(next_level[g] == external_edge_select[g]);
		end
	endgenerate
	assign port_change = pin_primed[3] &&
		(next_level[NPIN-1:NUM_EXT] != pin_level[NPIN-1:NUM_EXT]);

	// edges wait here so pin to vector spans three to four instruction cycles
	// whatever the core executes; costs a few flops per pin
	localparam int PIN_WAIT = `TLPIC_PIN_WAIT;
	logic [PIN_WAIT-1:0][NUM_EXT:0] edge_pipe;
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			edge_pipe <= '0;
		else
			edge_pipe <= {edge_pipe[PIN_WAIT-2:0], port_change, ext_edge};
	end

	// flags: set wins over clear, enables do not matter
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			periph_flag      <= '0;
			ext_flag         <= '0;
			port_change_flag <= 1'b0;
		end
		else
		begin
			periph_flag      <= (periph_flag & ~periph_flag_clear) | periph_event;
			ext_flag         <= (ext_flag & ~ext_flag_clear) |
				edge_pipe[PIN_WAIT-1][NUM_EXT-1:0];
			port_change_flag <= (port_change_flag & ~port_change_flag_clear) |
				edge_pipe[PIN_WAIT-1][NUM_EXT];
		end
	end

	// request qualification per level
	logic prio_on;
	assign prio_on = priority_scheme_enable;
	logic [NUM_PERIPH-1:0] p_act;
	logic [NUM_EXT-1:0]    e_act;
	logic                  c_act;
	assign p_act = periph_flag & periph_enable;
	assign e_act = ext_flag & ext_enable;
	assign c_act = port_change_flag & port_change_enable;

	logic want_high, want_low, want_compat;
	// core sources ignore peripheral group enable in compatibility mode
	assign want_compat = high_priority_global_enable &&
		(|e_act || c_act || (low_priority_global_enable && |p_act));
	assign want_high = high_priority_global_enable && (|(p_act & periph_priority) ||
		|(e_act & ext_priority) || (c_act && port_change_priority));
	assign want_low = low_priority_global_enable && (|(p_act & ~periph_priority) ||
		|(e_act & ~ext_priority) || (c_act && !port_change_priority));

	logic take_high, take_low;
	always_comb
	begin
		take_high = 1'b0;
		take_low  = 1'b0;
		if (!prio_on)
			take_high = want_compat && handler_level == tlpic_pkg::TLPIC_IDLE;
		else if (want_high && handler_level != tlpic_pkg::TLPIC_HIGH &&
			handler_level != tlpic_pkg::TLPIC_NEST)
			take_high = 1'b1;
		else if (want_low && handler_level == tlpic_pkg::TLPIC_IDLE)
			take_low = 1'b1;
	end

	// vector pulse goes out immediately; core stacks and jumps
	assign vector_request = take_high || take_low;
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			vector_address <= `TLPIC_VEC_HIGH;
			vector_is_high <= 1'b0;
		end
		else if (take_high || take_low)
		begin
			vector_address <= take_low ? `TLPIC_VEC_LOW : `TLPIC_VEC_HIGH;
			vector_is_high <= take_high;
		end
	end

	// priority scheme enable
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			priority_scheme_enable <= 1'b0;
		else if (priority_scheme_enable_wr)
			priority_scheme_enable <= priority_scheme_enable_in;
	end

	// global enables: hardware clear on entry, set on return (low only while priority_scheme_enable is set)
	logic ret_high, ret_low;
	assign ret_high = handler_return && (handler_level == tlpic_pkg::TLPIC_HIGH ||
		handler_level == tlpic_pkg::TLPIC_NEST);
	assign ret_low = handler_return && handler_level == tlpic_pkg::TLPIC_LOW;
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			high_priority_global_enable <= 1'b0;
			low_priority_global_enable  <= 1'b0;
		end
		else
		begin
			if (take_high)
				high_priority_global_enable <= 1'b0;
			else if (ret_high)
				high_priority_global_enable <= 1'b1;
			else if (global_high_wr)
				high_priority_global_enable <= global_high_in;
			if (take_low)
				low_priority_global_enable <= 1'b0;
			else if (ret_low && prio_on)
				low_priority_global_enable <= 1'b1;
			else if (global_low_wr)
				low_priority_global_enable <= global_low_in;
		end
	end

	// handler nesting level
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			handler_level <= tlpic_pkg::TLPIC_IDLE;
		else
			case (handler_level)
				tlpic_pkg::TLPIC_IDLE:
					if (take_high)
						handler_level <= tlpic_pkg::TLPIC_HIGH;
					else if (take_low)
						handler_level <= tlpic_pkg::TLPIC_LOW;
				tlpic_pkg::TLPIC_LOW:
					if (take_high)
						handler_level <= tlpic_pkg::TLPIC_NEST;
					else if (handler_return)
						handler_level <= tlpic_pkg::TLPIC_IDLE;
				tlpic_pkg::TLPIC_HIGH:
					if (handler_return)
						handler_level <= tlpic_pkg::TLPIC_IDLE;
				tlpic_pkg::TLPIC_NEST:
					if (handler_return)
						handler_level <= tlpic_pkg::TLPIC_LOW;
				default:
					handler_level <= tlpic_pkg::TLPIC_IDLE;
			endcase
	end

	// assertions
	property p_vec_low;
		@(posedge clock) disable iff (!reset_n)
		take_low |=> vector_address == `TLPIC_VEC_LOW && !vector_is_high;
	endproperty
	a_vec_low: assert property (p_vec_low) else $error("low vector wrong");
	property p_compat_single;
		@(posedge clock) disable iff (!reset_n)
		vector_request && !prio_on |=> vector_address == `TLPIC_VEC_HIGH;
	endproperty
	a_compat_single: assert property (p_compat_single) else $error("compat vector");
	property p_clear_on_take;
		@(posedge clock) disable iff (!reset_n)
		take_high |=> !high_priority_global_enable;
	endproperty
	a_clear_on_take: assert property (p_clear_on_take) else $error("enable kept");
	property p_no_low_in_high;
		@(posedge clock) disable iff (!reset_n)
		handler_level == tlpic_pkg::TLPIC_HIGH |-> !take_low;
	endproperty
	a_no_low_in_high: assert property (p_no_low_in_high) else $error("low in high");
	property p_restore;
		@(posedge clock) disable iff (!reset_n)
		ret_high && !take_high |=> high_priority_global_enable;
	endproperty
	a_restore: assert property (p_restore) else $error("no restore");
	property p_flag_set;
		@(posedge clock) disable iff (!reset_n)
		periph_event[0] |=> periph_flag[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag lost");
	property p_immediate;
		@(posedge clock) disable iff (!reset_n)
		prio_on && want_high && handler_level == tlpic_pkg::TLPIC_IDLE |-> vector_request;
	endproperty
	a_immediate: assert property (p_immediate) else $error("no vector");
	property p_nest;
		@(posedge clock) disable iff (!reset_n)
		handler_level == tlpic_pkg::TLPIC_LOW && take_high |=>
			handler_level == tlpic_pkg::TLPIC_NEST;
	endproperty
	a_nest: assert property (p_nest) else $error("no nesting");
	// eight clocks of wait stage between a settled edge and its flag
	property p_ext_latency;
		@(posedge clock) disable iff (!reset_n)
		ext_edge[0] && !ext_flag[0] |=> !ext_flag[0] [*8] ##1 ext_flag[0];
	endproperty
	a_ext_latency: assert property (p_ext_latency) else $error("pin latency");

	c_high: cover property (@(posedge clock) disable iff (!reset_n) take_high && prio_on);
	c_low: cover property (@(posedge clock) disable iff (!reset_n) take_low);
	c_nest: cover property (@(posedge clock) disable iff (!reset_n)
		handler_level == tlpic_pkg::TLPIC_NEST);
	c_port: cover property (@(posedge clock) disable iff (!reset_n) port_change);

endmodule

// file: verification/tlpic_core_model.sv
/*
 core side model: loads the vector into its program counter, keeps a return stack and
 pulses handler_return when the bench ends a handler.
 assumes vector_address is valid one cycle after vector_request.
*/
`timescale 1ns/1ps
module tlpic_core_model
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// controller side
	input  wire logic        vector_request,
	input  wire logic [20:0] vector_address,
	output logic             handler_return,
	// bench side
	input  wire logic        leave,
	output logic [20:0]      program_counter
);
	logic [20:0] ret_stack [0:3];
	logic [1:0]  depth;
	logic        load_pc;
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			program_counter <= 21'h000100;
			depth <= 2'h0;
			load_pc <= 1'b0;
			handler_return <= 1'b0;
		end
		else
		begin
			load_pc <= vector_request;
			handler_return <= leave && !handler_return;
			if (vector_request)
			begin
				ret_stack[depth] <= program_counter;
				depth <= depth + 2'h1;
			end
			else if (handler_return)
				depth <= depth - 2'h1;
			// bench never ends a handler in the cycle after a vector
			if (load_pc)
				program_counter <= vector_address;
			else if (handler_return)
				program_counter <= ret_stack[depth - 2'h1];
			else
				program_counter <= program_counter + 21'h000001;
		end
	end
endmodule

// file: verification/tb_top.sv
/*
 testbench for the interrupt controller: directed corner cases plus seeded random requests.
 assumes the core model answers vectors; inputs change at the falling edge.
*/
`timescale 1ns/1ps
`include "tlpic_defs.svh"
module tb_top;
	logic clock = 0, reset_n = 0, leave = 0, handler_return;
	logic priority_scheme_enable_wr = 0, priority_scheme_enable_in = 0;
	logic global_high_wr = 0, global_high_in = 0, global_low_wr = 0, global_low_in = 0;
	logic [7:0] periph_enable = 0, periph_priority = 0, periph_flag_clear = 0, periph_event = 0;
	logic [2:0] ext_enable = 0, ext_priority = 0, external_edge_select = 0;
	logic [2:0] ext_flag_clear = 0, external_interrupt_pins = 3'h2;
	logic port_change_enable = 0, port_change_priority = 0, port_change_flag_clear = 0;
	logic [3:0] port_b_upper = 0;
	logic vector_request, vector_is_high, priority_scheme_enable, port_change_flag;
	logic high_priority_global_enable, low_priority_global_enable;
	logic [20:0] vector_address, program_counter;
	logic [7:0] periph_flag, m;
	logic [2:0] ext_flag;
	tlpic_pkg::tlpic_level_type handler_level;
	int err_total = 0, cmp_count = 0, seed = 88389, lat, k;

	always #50 clock = ~clock;

	tlpic_ctrl dut_u (.clock, .reset_n, .priority_scheme_enable_wr, .priority_scheme_enable_in,
		.global_high_wr, .global_high_in, .global_low_wr, .global_low_in, .periph_enable,
		.periph_priority, .ext_enable, .ext_priority, .external_edge_select,
		.port_change_enable, .port_change_priority, .periph_flag_clear, .ext_flag_clear,
		.port_change_flag_clear, .periph_event, .external_interrupt_pins, .port_b_upper,
		.handler_return, .vector_request, .vector_address, .vector_is_high,
		.priority_scheme_enable, .high_priority_global_enable, .low_priority_global_enable,
		.periph_flag, .ext_flag, .port_change_flag, .handler_level);
	tlpic_core_model core_u (.clock, .reset_n, .vector_request, .vector_address,
		.handler_return, .leave, .program_counter);

	task test_done;
		$display("checks %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task step(input int n);
		repeat (n) @(negedge clock);
	endtask
	task setg(input logic p, input logic h, input logic l);
		{priority_scheme_enable_wr, global_high_wr, global_low_wr} = 3'h7; // single strobes
		{priority_scheme_enable_in, global_high_in, global_low_in} = {p, h, l};
		step(1);
		{priority_scheme_enable_wr, global_high_wr, global_low_wr} = 3'h0;
	endtask
	task fire(input logic [7:0] v);
		periph_event = v;
		step(1);
		periph_event = 8'h00;
	endtask
	task clr(input logic [7:0] v);
		periph_flag_clear = v;
		step(1);
		periph_flag_clear = 8'h00;
	endtask
	task ret;
		leave = 1;
		step(1);
		leave = 0;
		step(1);
	endtask
	// waits for the vector, then checks the address and the program counter
	task vec(input logic [20:0] a, output int n);
		for (n = 0; n < 24 && vector_request !== 1'b1; n++)
			step(1);
		if (n == 24)
		begin
			chk("vector_request", 0, 1);
			test_done();
		end
		step(1);
		chk("vector_address", vector_address, a);
		step(1);
		chk("program_counter", program_counter, a);
	endtask
	function automatic logic [20:0] exp_vec(input logic p, input logic hi);
		return (p && !hi) ? `TLPIC_VEC_LOW : `TLPIC_VEC_HIGH;
	endfunction

	initial
	begin
		step(2);
		reset_n = 1;
		step(1);
		chk("prio_enable", priority_scheme_enable, 0);
		chk("globals", {high_priority_global_enable, low_priority_global_enable}, 0);
		chk("level", handler_level, tlpic_pkg::TLPIC_IDLE);
		fire(8'h81);
		step(1);
		chk("periph_flag", periph_flag, 8'h81);
		chk("vector_request", vector_request, 0);
		clr(8'hFF);
		periph_enable = 8'h01;
		periph_priority = 8'h01;
		setg(0, 1, 0);
		fire(8'h01);
		step(3);
		chk("vector_request", vector_request, 0);
		setg(0, 1, 1);
		vec(`TLPIC_VEC_HIGH, lat);
		chk("global_high", high_priority_global_enable, 0);
		clr(8'h01);
		ret;
		chk("global_high", high_priority_global_enable, 1);
		setg(1, 1, 1);
		chk("prio_enable", priority_scheme_enable, 1);
		periph_priority = 8'h02;
		periph_enable = 8'h03;
		fire(8'h01);
		vec(`TLPIC_VEC_LOW, lat);
		chk("globals", {high_priority_global_enable, low_priority_global_enable}, 2);
		fire(8'h02);
		vec(`TLPIC_VEC_HIGH, lat);
		chk("level", handler_level, tlpic_pkg::TLPIC_NEST);
		clr(8'h03);
		ret;
		chk("level", handler_level, tlpic_pkg::TLPIC_LOW);
		ret;
		chk("global_low", low_priority_global_enable, 1);
		fire(8'h03);
		vec(`TLPIC_VEC_HIGH, lat);
		chk("is_high", vector_is_high, 1);
		for (k = 0; k < 5; k++)
		begin
			step(1);
			chk("vector_request", vector_request, 0);
		end
		clr(8'h02);
		ret;
		vec(`TLPIC_VEC_LOW, lat);
		clr(8'h01);
		ret;
		{ext_enable, ext_priority, external_edge_select} = {3'h3, 3'h3, 3'h1};
		external_interrupt_pins = 3'h3;
		vec(`TLPIC_VEC_HIGH, lat);
		chk("latency", lat >= 3 * `TLPIC_CLK_PER_INSTR && lat <= 4 * `TLPIC_CLK_PER_INSTR, 1);
		ext_flag_clear = 3'h1;
		step(1);
		ext_flag_clear = 3'h0;
		ret;
		external_interrupt_pins = 3'h2;
		step(14);
		chk("ext_flag", ext_flag, 0);
		external_interrupt_pins = 3'h0;
		vec(`TLPIC_VEC_HIGH, lat);
		chk("latency", lat >= 3 * `TLPIC_CLK_PER_INSTR && lat <= 4 * `TLPIC_CLK_PER_INSTR, 1);
		ext_flag_clear = 3'h2;
		step(1);
		ext_flag_clear = 3'h0;
		ret;
		port_b_upper = 4'h4;
		step(14);
		chk("port_change_flag", port_change_flag, 1);
		port_change_flag_clear = 1;
		step(1);
		port_change_flag_clear = 0;
		periph_enable = 8'hFF;
		for (k = 0; k < 12; k++)
		begin
			m = 8'($random(seed));
			periph_priority = 8'($random(seed));
			setg(m[0], 1, 1);
			fire(8'h01 << m[3:1]);
			vec(exp_vec(m[0], periph_priority[m[3:1]]), lat);
			clr(8'hFF);
			ret;
		end
		test_done();
	end
endmodule
